// file: rtl/cwb_consts.vh
`ifndef CWB_CONSTS_VH
`define CWB_CONSTS_VH
`define CWB_DATA_DEPTH   16
`define CWB_ADDR_DEPTH   4
`define CWB_TCM_MAX_LOG2 5'd16
`define CWB_HTRANS_IDLE  2'b00
`define CWB_HTRANS_NSEQ  2'b10
`define CWB_HTRANS_SEQ   2'b11
`define CWB_HBURST_SINGLE 3'b000
`define CWB_HBURST_WRAP8  3'b100
`define CWB_HBURST_INCR4  3'b011
`define CWB_HBURST_INCR8  3'b101
`define CWB_HSIZE_BYTE   3'b000
`define CWB_HSIZE_HALF   3'b001
`define CWB_HSIZE_WORD   3'b010
`define CWB_KIND_STORE   2'd0
`define CWB_KIND_HALFWB  2'd1
`define CWB_KIND_LINEWB  2'd2
`define CWB_KIND_LINEFIL 2'd3
`endif

// file: rtl/cwb_skid.v
`timescale 1ns/1ps
// two-entry buffer; upstream ready depends only on occupancy, so no combinational path from downstream
module cwb_skid #(
	parameter W = 32
) (
	input  wire         clock,
	input  wire         rstn,
	input  wire         in_valid,
	output wire         in_ready,
	input  wire [W-1:0] in_data,
	output wire         out_valid,
	input  wire         out_ready,
	output wire [W-1:0] out_data
);
	reg [W-1:0] mem_r [0:1];
	reg         wp_r;
	reg         rp_r;
	reg [1:0]   cnt_r;
	wire        push;
	wire        pop;
	assign in_ready  = (cnt_r != 2'd2);
	assign out_valid = (cnt_r != 2'd0);
	assign out_data  = mem_r[rp_r];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			wp_r     <= 1'b0;
			rp_r     <= 1'b0;
			cnt_r    <= 2'd0;
			mem_r[0] <= {W{1'b0}};
			mem_r[1] <= {W{1'b0}};
		end else begin
			if (push) begin
				mem_r[wp_r] <= in_data;
				wp_r        <= ~wp_r;
			end
			if (pop)
				rp_r <= ~rp_r;
			if (push & ~pop)
				cnt_r <= cnt_r + 2'd1;
			else if (pop & ~push)
				cnt_r <= cnt_r - 2'd1;
		end
	end
endmodule

// file: rtl/cwb_biu.v
`timescale 1ns/1ps
`include "cwb_consts.vh"
// Operation
// - buffer holds sixteen data words and four pending store addresses
// - all bufferable, write-through and write-back miss stores outside tight memory go through the buffer
// - stores taken at core speed, drained to bus while core runs
// - cacheable and bufferable descriptor bits select each region's write policy
// - write-through hit updates cache line and also queues data for memory
// - write-back hit marks only the half line picked by address bit 4 dirty, no bus write
// - instruction and data tight memory sizes set separately, zero to 64 KB
// - data port may read and write instruction tight memory
// - one instruction region and one data region, placed anywhere
// - tight memory accesses have fixed latency and make no bus transfer
// - only single, four-word and eight-word bursts; other lengths are cut to single transfers
// - plain AHB-Lite, no split or retry responses expected or produced
// - single transfers for missed stores, uncached reads, fetches, table walks
// - four-word bursts for half-line write-back, prefetch, four-word writes
// - eight-word bursts for line write-back and writes; wrapping eight for linefill
// - every instruction fetch is a full word access
// - halfword and word addresses forced onto their natural boundaries
// - single master per layer; arbitration only in the interconnect
// - two dirty bits per eight-word line select whole, half or no write-back
module cwb_biu #(
	parameter DEPTH_D = `CWB_DATA_DEPTH,
	parameter DEPTH_A = `CWB_ADDR_DEPTH
) (
	input  wire        clock,
	input  wire        rstn,
	// core store port: one beat per cycle; first beat carries address and kind
	input  wire        st_valid,
	output reg         st_ready_r,
	input  wire        st_first,
	input  wire [3:0]  st_len,
	input  wire [31:0] st_addr,
	input  wire [31:0] st_data,
	input  wire [2:0]  st_size,
	input  wire        st_cacheable,
	input  wire        st_bufferable,
	input  wire        st_hit,
	input  wire [1:0]  st_dirty,
	// core read / fetch port
	input  wire        rd_valid,
	output reg         rd_ready_r,
	input  wire [31:0] rd_addr,
	input  wire [2:0]  rd_size,
	input  wire        rd_fetch,
	input  wire        rd_linefill,
	input  wire        rd_prefetch,
	output reg         rd_data_valid_r,
	output reg  [31:0] rd_data_r,
	// tight memory configuration and access results
	input  wire [4:0]  itm_size_log2,
	input  wire [31:0] itm_base,
	input  wire        itm_enable,
	input  wire [4:0]  dtm_size_log2,
	input  wire [31:0] dtm_base,
	input  wire        dtm_enable,
	output reg         tcm_hit_r,
	output reg         tcm_is_instr_r,
	output reg  [15:0] tcm_addr_r,
	output reg         dirty_set_r,
	output reg  [1:0]  dirty_half_r,
	output reg         wb_empty_r,
	// AHB-Lite master
	output reg  [31:0] haddr_r,
	output reg  [1:0]  htrans_r,
	output reg         hwrite_r,
	output reg  [2:0]  hsize_r,
	output reg  [2:0]  hburst_r,
	output reg  [31:0] hwdata_r,
	input  wire        hready,
	input  wire        hresp,
	input  wire [31:0] hrdata
);
	localparam S_IDLE = 2'd0;
	localparam S_ADDR = 2'd1;
	localparam S_LAST = 2'd2;
	localparam AW = 4;
	localparam PW = 2;

	reg  [31:0]  dmem_r [0:DEPTH_D-1];
	reg  [39:0]  amem_r [0:DEPTH_A-1];
	reg  [AW:0]  dcnt_r;
	reg  [AW-1:0] dwp_r;
	reg  [AW-1:0] drp_r;
	reg  [PW:0]  acnt_r;
	reg  [PW-1:0] awp_r;
	reg  [PW-1:0] arp_r;
	reg  [1:0]   st_r;
	reg  [3:0]   beats_r;
	reg  [3:0]   left_r;
	reg          is_rd_r;
	reg  [31:0]  rdaddr_r;
	wire [39:0]  acur;
	wire         in_itm;
	wire         in_dtm;
	wire         st_tcm;
	wire         st_buffered;
	wire         st_take;
	wire         a_push;
	wire         a_pop;
	wire         d_pop;
	wire [3:0]   st_beats;
	wire [31:0]  st_al;
	wire         sk_in_ready;
	wire         sk_valid;
	wire [31:0]  sk_data;
	wire         rd_go;
	wire [31:0]  rd_al;
	wire         burst_ready;
	wire         d_room;
	wire         a_room;
	wire [2:0]   wr_burst;
	wire [2:0]   rd_burst;
	wire [3:0]   rd_beats;

	function [31:0] align;
		input [31:0] a;
		input [2:0]  sz;
		begin
			if (sz == `CWB_HSIZE_WORD)
				align = {a[31:2], 2'b00};
			else if (sz == `CWB_HSIZE_HALF)
				align = {a[31:1], 1'b0};
			else
				align = a;
		end
	endfunction

	function match;
		input [31:0] a;
		input [31:0] base;
		input [4:0]  lg;
		input        en;
		reg   [31:0] msk;
		begin
			msk   = 32'hffffffff << lg;
			match = en && (lg != 5'd0) && (lg <= `CWB_TCM_MAX_LOG2) && ((a & msk) == (base & msk));
		end
	endfunction

	// data side decodes both regions so it can load code into the instruction memory
	assign in_itm = match(st_addr, itm_base, itm_size_log2, itm_enable);
	assign in_dtm = match(st_addr, dtm_base, dtm_size_log2, dtm_enable);
	assign st_tcm = in_itm | in_dtm;
	// write-back hit only dirties the line; tight memory stores also skip it; all else goes through the buffer
	assign st_buffered = ~st_tcm & ~(st_cacheable & st_bufferable & st_hit);
	// lengths other than 1, 4 or 8 are cut to single beats
	assign st_beats = (st_len == 4'd4 || st_len == 4'd8) ? st_len : 4'd1;
	assign st_al    = align(st_addr, st_size);
	assign st_take  = st_valid & st_ready_r;
	assign a_push   = st_take & st_first & st_buffered;
	assign acur     = amem_r[arp_r];
	assign d_pop    = (st_r == S_ADDR || st_r == S_LAST) & hready & ~is_rd_r & (left_r != 4'd0);
	assign a_pop    = (st_r == S_ADDR) & ~is_rd_r & hready & (left_r == 4'd1);
	assign rd_al    = rd_fetch ? {rd_addr[31:2], 2'b00} : align(rd_addr, rd_size);
	assign rd_go    = rd_valid & rd_ready_r & ~match(rd_addr, itm_base, itm_size_log2, itm_enable)
	                  & ~match(rd_addr, dtm_base, dtm_size_log2, dtm_enable);
	// burst waits for all its beats, else a stalled core lets the bus read stale words
	assign burst_ready = (dcnt_r >= {1'b0, acur[3:0]});
	assign d_room      = ((dcnt_r + {1'b0, st_beats} + 5'd1) <= DEPTH_D);
	assign a_room      = (acnt_r + 3'd1 < DEPTH_A);
	assign wr_burst    = (acur[3:0] == 4'd8) ? `CWB_HBURST_INCR8 :
	                     (acur[3:0] == 4'd4) ? `CWB_HBURST_INCR4 : `CWB_HBURST_SINGLE;
	assign rd_burst    = rd_linefill ? `CWB_HBURST_WRAP8 :
	                     rd_prefetch ? `CWB_HBURST_INCR4 : `CWB_HBURST_SINGLE;
	assign rd_beats    = rd_linefill ? 4'd8 : (rd_prefetch ? 4'd4 : 4'd1);

	cwb_skid #(
		.W(32)
	) u_rd_skid (
		.clock     (clock),
		.rstn      (rstn),
		.in_valid  (is_rd_r & (st_r != S_IDLE) & hready & (left_r != beats_r)),
		.in_ready  (sk_in_ready),
		.in_data   (hrdata),
		.out_valid (sk_valid),
		.out_ready (1'b1),
		.out_data  (sk_data)
	);

	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			dcnt_r <= {(AW+1){1'b0}};
			dwp_r  <= {AW{1'b0}};
			drp_r  <= {AW{1'b0}};
			acnt_r <= {(PW+1){1'b0}};
			awp_r  <= {PW{1'b0}};
			arp_r  <= {PW{1'b0}};
			st_ready_r <= 1'b0;
			tcm_hit_r <= 1'b0;
			tcm_is_instr_r <= 1'b0;
			tcm_addr_r <= 16'h0000;
			dirty_set_r <= 1'b0;
			dirty_half_r <= 2'b00;
			wb_empty_r <= 1'b1;
		end else begin
			// core sees ready while a whole burst plus one word and two addresses still fit
			st_ready_r <= d_room && a_room;
			if (st_take & st_buffered) begin
				dmem_r[dwp_r] <= st_data;
				dwp_r <= dwp_r + 4'd1;
			end
			if (a_push) begin
				amem_r[awp_r] <= {st_al, st_size, 1'b0, st_beats};
				awp_r <= awp_r + 2'd1;
			end
			if (a_pop)
				arp_r <= arp_r + 2'd1;
			if (d_pop)
				drp_r <= drp_r + 4'd1;
			dcnt_r <= dcnt_r + {4'd0, st_take & st_buffered} - {4'd0, d_pop};
			acnt_r <= acnt_r + {2'd0, a_push} - {2'd0, a_pop};
			wb_empty_r <= (acnt_r == 3'd0) && (dcnt_r == 5'd0);
			tcm_hit_r <= st_take & st_tcm;
			tcm_is_instr_r <= in_itm;
			tcm_addr_r <= st_addr[15:0];
			dirty_set_r <= st_take & st_first & st_cacheable & st_bufferable & st_hit;
			dirty_half_r <= st_addr[4] ? 2'b10 : 2'b01;
		end
	end

	// bus sequencer: one master on this layer, so no request or grant
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			st_r <= S_IDLE;
			haddr_r <= 32'h00000000;
			htrans_r <= `CWB_HTRANS_IDLE;
			hwrite_r <= 1'b0;
			hsize_r <= `CWB_HSIZE_WORD;
			hburst_r <= `CWB_HBURST_SINGLE;
			hwdata_r <= 32'h00000000;
			beats_r <= 4'd0;
			left_r <= 4'd0;
			is_rd_r <= 1'b0;
			rdaddr_r <= 32'h00000000;
			rd_ready_r <= 1'b0;
			rd_data_valid_r <= 1'b0;
			rd_data_r <= 32'h00000000;
		end else begin
			rd_data_valid_r <= sk_valid;
			rd_data_r <= sk_data;
			rd_ready_r <= (st_r == S_IDLE) & (acnt_r == 3'd0) & ~rd_ready_r & sk_in_ready;
			case (st_r)
			S_IDLE: begin
				htrans_r <= `CWB_HTRANS_IDLE;
				if (acnt_r != 3'd0 && burst_ready) begin
					// oldest store first keeps bus order equal to store order
					haddr_r  <= acur[39:8];
					hsize_r  <= acur[7:5];
					hwrite_r <= 1'b1;
					hburst_r <= wr_burst;
					htrans_r <= `CWB_HTRANS_NSEQ;
					beats_r  <= acur[3:0];
					left_r   <= acur[3:0];
					is_rd_r  <= 1'b0;
					st_r     <= S_ADDR;
				end else if (rd_go && acnt_r == 3'd0) begin
					haddr_r  <= rd_al;
					hsize_r  <= (rd_fetch | rd_linefill | rd_prefetch) ? `CWB_HSIZE_WORD : rd_size;
					hwrite_r <= 1'b0;
					hburst_r <= rd_burst;
					beats_r  <= rd_beats;
					left_r   <= rd_beats;
					htrans_r <= `CWB_HTRANS_NSEQ;
					is_rd_r  <= 1'b1;
					rdaddr_r <= rd_al;
					st_r     <= S_ADDR;
				end
			end
			S_ADDR: begin
				// error response is plain AHB-Lite; split and retry never come
				if (hready) begin
					if (~is_rd_r)
						hwdata_r <= dmem_r[drp_r];
					left_r <= left_r - 4'd1;
					if (left_r == 4'd1) begin
						htrans_r <= `CWB_HTRANS_IDLE;
						st_r <= S_LAST;
					end else begin
						htrans_r <= `CWB_HTRANS_SEQ;
						if (hburst_r == `CWB_HBURST_WRAP8)
							haddr_r <= {haddr_r[31:5], haddr_r[4:2] + 3'd1, 2'b00};
						else
							haddr_r <= haddr_r + 32'd4;
					end
				end
			end
			S_LAST: begin
				if (hready | hresp)
					st_r <= S_IDLE;
			end
			default: st_r <= S_IDLE;
			endcase
		end
	end
endmodule

// file: tb/cwb_asserts.sv
`timescale 1ns/1ps
`include "cwb_consts.vh"
module cwb_asserts (
	input wire        clock,
	input wire        rstn,
	input wire        st_valid,
	input wire        st_ready_r,
	input wire        st_first,
	input wire        st_cacheable,
	input wire        st_bufferable,
	input wire        st_hit,
	input wire        dirty_set_r,
	input wire        tcm_hit_r,
	input wire [31:0] haddr_r,
	input wire [1:0]  htrans_r,
	input wire        hwrite_r,
	input wire [2:0]  hsize_r,
	input wire [2:0]  hburst_r,
	input wire        hready
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	wire act    = htrans_r[1];
	wire wb_hit = st_valid && st_ready_r && st_first && st_cacheable && st_bufferable && st_hit;
	req_hold_a: assert property (act && !hready |=> $stable({haddr_r, htrans_r, hburst_r, hwrite_r}))
		else $error("bus request changed during wait");
	burst_kind_a: assert property (htrans_r == `CWB_HTRANS_NSEQ |-> hburst_r inside {`CWB_HBURST_SINGLE,
		`CWB_HBURST_INCR4, `CWB_HBURST_INCR8, `CWB_HBURST_WRAP8}) else $error("illegal burst kind");
	seq_burst_a: assert property (htrans_r == `CWB_HTRANS_SEQ |-> hburst_r != `CWB_HBURST_SINGLE)
		else $error("sequential beat in single transfer");
	incr_step_a: assert property (htrans_r == `CWB_HTRANS_SEQ && hburst_r[0] && $past(hready)
		|-> haddr_r == $past(haddr_r) + 32'h4) else $error("incrementing burst address step wrong");
	wrap_read_a: assert property (act && hburst_r == `CWB_HBURST_WRAP8 |-> !hwrite_r)
		else $error("wrapping burst used for a write");
	half_align_a: assert property (act && hsize_r == `CWB_HSIZE_HALF |-> !haddr_r[0])
		else $error("halfword address not aligned");
	word_align_a: assert property (act && hsize_r == `CWB_HSIZE_WORD |-> haddr_r[1:0] == 2'h0)
		else $error("word address not aligned");
	dirty_mark_a: assert property (wb_hit |-> ##[1:2] dirty_set_r)
		else $error("write-back hit not marked dirty");
	cover property (htrans_r == `CWB_HTRANS_NSEQ && hburst_r == `CWB_HBURST_INCR8);
	cover property (htrans_r == `CWB_HTRANS_NSEQ && hburst_r == `CWB_HBURST_INCR4);
	cover property (dirty_set_r);
	cover property (tcm_hit_r);
endmodule
bind cwb_biu cwb_asserts cwb_chk (.clock, .rstn, .st_valid, .st_ready_r, .st_first, .st_cacheable, .st_bufferable,
	.st_hit, .dirty_set_r, .tcm_hit_r, .haddr_r, .htrans_r, .hwrite_r, .hsize_r, .hburst_r, .hready);

// file: tb/cwb_ahb_slave.sv
`timescale 1ns/1ps
module cwb_ahb_slave (
	input  wire        clock,
	input  wire        rstn,
	input  wire        slow,
	output reg         hready,
	output wire        hresp,
	output reg  [31:0] hrdata
);
	// single master per layer: only okay responses, never split or retry
	assign hresp = 1'b0;
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			hready <= 1'b1;
			hrdata <= 32'h0;
		end else begin
			// wait state every other cycle when slow, so the buffer backs up
			hready <= !slow || !hready;
			hrdata <= ~hrdata + 32'h3;
		end
	end
endmodule

// file: tb/core_write_buffer_ahb_biu_bench.sv
`timescale 1ns/1ps
`include "cwb_consts.vh"
module core_write_buffer_ahb_biu_bench;
	logic        clock = 1'b0, rstn = 1'b0, slow = 1'b0, st_valid = 1'b0, st_first = 1'b0;
	logic        st_cacheable = 1'b0, st_bufferable = 1'b0, st_hit = 1'b0, itm_enable = 1'b1, dtm_enable = 1'b1;
	logic        rd_valid = 1'b0, rd_fetch = 1'b0, rd_linefill = 1'b0, rd_prefetch = 1'b0, dp = 1'b0;
	logic [3:0]  st_len = 4'h0;
	logic [31:0] st_addr = '0, st_data = '0, rd_addr = '0, itm_base = 32'h0, dtm_base = 32'h2000_0000;
	logic [2:0]  st_size = 3'h0, rd_size = 3'h0;
	logic [1:0]  st_dirty = 2'h0;
	logic [4:0]  itm_size_log2 = 5'hc, dtm_size_log2 = 5'hc; // bases aligned to size, disjoint
	wire  [15:0] tcm_addr_r;
	wire         st_ready_r, rd_ready_r, rd_data_valid_r, tcm_hit_r, tcm_is_instr_r, dirty_set_r, wb_empty_r;
	wire         hwrite_r, hready, hresp;
	wire [1:0]   dirty_half_r, htrans_r;
	wire [31:0]  rd_data_r, haddr_r, hwdata_r, hrdata;
	wire [2:0]   hsize_r, hburst_r;
	int          n_mismatch = 0, checks = 0, stalls = 0;
	logic [31:0] aq[$], wq[$], bq[$], sq[$], ra[$], rs[$];
	cwb_biu uut (.clock, .rstn, .st_valid, .st_ready_r, .st_first, .st_len, .st_addr, .st_data, .st_size,
		.st_cacheable, .st_bufferable, .st_hit, .st_dirty, .rd_valid, .rd_ready_r, .rd_addr, .rd_size, .rd_fetch,
		.rd_linefill, .rd_prefetch, .rd_data_valid_r, .rd_data_r, .itm_size_log2, .itm_base, .itm_enable,
		.dtm_size_log2, .dtm_base, .dtm_enable, .tcm_hit_r, .tcm_is_instr_r, .tcm_addr_r, .dirty_set_r,
		.dirty_half_r, .wb_empty_r, .haddr_r, .htrans_r, .hwrite_r, .hsize_r, .hburst_r, .hwdata_r, .hready,
		.hresp, .hrdata);
	cwb_ahb_slave far_side (.clock, .rstn, .slow, .hready, .hresp, .hrdata);
	always #5 clock = ~clock;
	// sampled at the falling edge: the values the next rising edge will take
	always @(negedge clock) if (hready) begin
		if (dp)
			wq.push_back(hwdata_r);
		dp = htrans_r[1] && hwrite_r;
		if (dp) begin
			aq.push_back(haddr_r);
			bq.push_back(hburst_r);
			sq.push_back(hsize_r);
		end
		if (htrans_r[1] && !hwrite_r) begin
			ra.push_back(haddr_r);
			rs.push_back(hsize_r);
		end
	end
	task automatic chk(input string n, input logic [31:0] e, g);
		checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic pol(input logic [2:0] sz, input logic c, b, h);
		@(posedge clock);
		st_size <= sz;
		st_cacheable <= c;
		st_bufferable <= b;
		st_hit <= h;
		aq.delete();
		wq.delete();
		bq.delete();
		sq.delete();
	endtask
	// holds st_valid up between beats; the caller drops it once
	task automatic beat(input logic [31:0] a, d, input logic [3:0] len, input logic f);
		st_valid <= 1'b1;
		st_first <= f;
		st_len <= len;
		st_addr <= a;
		st_data <= d;
		@(negedge clock);
		for (int k = 0; k < 200 && !st_ready_r; k++) begin
			stalls++;
			@(negedge clock);
		end
		@(posedge clock);
	endtask
	task automatic waitw(input int n);
		for (int k = 0; k < 400 && wq.size() < n; k++) @(posedge clock);
	endtask
	task automatic t_bursts;
		logic [3:0] lv[4] = '{4'h1, 4'h3, 4'h4, 4'h8};
		logic [2:0] bv[4] = '{`CWB_HBURST_SINGLE, `CWB_HBURST_SINGLE, `CWB_HBURST_INCR4, `CWB_HBURST_INCR8};
		for (int m = 0; m < 4; m++) begin
			pol(`CWB_HSIZE_WORD, m == 2, m != 2, m == 2);
			slow <= m == 3;
			for (int j = 0; j < lv[m]; j++)
				beat(32'h1000_0040 + 4 * j, 32'ha5 + j, lv[m], j == 0 || m < 2);
			st_valid <= 1'b0;
			waitw(lv[m]);
			for (int j = 0; j < lv[m]; j++) begin
				chk("burst", bv[m], bq[j]);
				chk("addr", 32'h1000_0040 + 4 * j, aq[j]);
				chk("data", 32'ha5 + j, wq[j]);
			end
		end
		slow <= 1'b0;
	endtask
	task automatic t_align;
		pol(`CWB_HSIZE_HALF, 1'b0, 1'b1, 1'b0);
		beat(32'h1000_0103, 32'h1234, 4'h1, 1'b1);
		st_valid <= 1'b0;
		waitw(1);
		chk("half addr", 32'h1000_0102, aq[0]);
		chk("half size", `CWB_HSIZE_HALF, sq[0]);
	endtask
	task automatic t_nobus;
		logic [31:0] av[3] = '{32'h1000_0300, 32'h2000_0010, 32'h0000_0020};
		logic d, t, ti;
		logic [1:0] dh;
		logic [15:0] ta;
		for (int m = 0; m < 3; m++) begin
			pol(`CWB_HSIZE_WORD, m == 0, m == 0, m == 0);
			{d, t, ti} = 3'h0;
			dh = 2'h0;
			ta = 16'h0;
			beat(av[m], 32'h77, 4'h1, 1'b1);
			st_valid <= 1'b0;
			repeat (4) begin
				@(negedge clock);
				d |= dirty_set_r;
				t |= tcm_hit_r;
				ti |= tcm_hit_r && tcm_is_instr_r;
				if (dirty_set_r)
					dh = dirty_half_r;
				if (tcm_hit_r)
					ta = tcm_addr_r;
			end
			waitw(1);
			chk("dirty", m == 0, d);
			chk("tcm hit", m > 0, t);
			chk("instr tcm", m == 2, ti);
			chk("dirty half", m == 0 ? 2'b01 : 2'b00, dh);
			chk("tcm addr", m > 0 ? av[m][15:0] : 16'h0, ta);
			chk("bus writes", 0, aq.size());
		end
	endtask
	task automatic t_fetch;
		logic v = 1'b0;
		ra.delete();
		rs.delete();
		rd_addr <= 32'h1000_0203;
		rd_size <= `CWB_HSIZE_BYTE;
		rd_fetch <= 1'b1;
		rd_valid <= 1'b1;
		@(negedge clock);
		for (int k = 0; k < 100 && !rd_ready_r; k++) @(negedge clock);
		@(posedge clock);
		rd_valid <= 1'b0;
		repeat (40) begin
			@(negedge clock);
			v |= rd_data_valid_r;
		end
		chk("fetch addr", 32'h1000_0200, ra[0]);
		chk("fetch size", `CWB_HSIZE_WORD, rs[0]);
		chk("fetch data", 1, v);
	endtask
	task automatic t_fill;
		pol(`CWB_HSIZE_WORD, 1'b0, 1'b1, 1'b0);
		slow <= 1'b1;
		stalls = 0;
		for (int j = 0; j < 20; j++)
			beat(32'h1000_0800 + 4 * j, 32'hc0 + j, 4'h1, 1'b1);
		st_valid <= 1'b0;
		waitw(20);
		slow <= 1'b0;
		chk("stalled", 1, stalls > 0);
		repeat (4) @(posedge clock);
		chk("buffer empty", 1, wb_empty_r);
		for (int j = 0; j < 20; j++)
			chk("fill data", 32'hc0 + j, wq[j]);
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge clock);
		rstn <= 1'b1;
		repeat (2) @(posedge clock);
		t_bursts;
		t_align;
		t_nobus;
		t_fetch;
		t_fill;
		final_report;
	end
	// whole run is under two thousand cycles; this limit only cuts a hang
	initial begin
		#300us;
		n_mismatch++;
		final_report;
	end
endmodule
